// ===== hw/seep_port.sv
// serial command port of a 512-byte nonvolatile memory, pins sampled on ref_clk_i
module seep_port #(
  parameter int unsigned TWC_CYCLES = seep_pkg::TWC_CYCLES_DFLT
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire seep_pkg::seep_pins_s pins_i,
  output logic so_o,
  output logic so_oe_o,
  output logic busy_o,
  output logic wel_o,
  output logic [seep_pkg::DATA_W-1:0] status_o
);
  import seep_pkg::*;

  localparam logic [TWC_W-1:0] TWC_LAST = TWC_W'(TWC_CYCLES - 1);

  // pin synchronisers and edge history
  seep_pins_s sync1_r;
  seep_pins_s sync2_r;
  logic sck_q_r;
  logic cs_q_r;

  // frame state
  seep_state_e state_r;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [DATA_W-1:0] sh_r;
  logic [DATA_W-1:0] sh_nxt;
  logic [ADDR_W-1:0] ptr_r;
  logic is_wr_r;
  logic got_byte_r;
  logic latch_set_r;
  logic [1:0] stage_bp_r;
  logic [PAGE_BYTES-1:0] valid_r;
  logic paused_r;
  logic [DATA_W-1:0] osh_r;
  logic [BIT_CNT_W-1:0] ocnt_r;
  logic drive_r;
  logic so_r;

  // write cycle engine
  logic busy_r;
  logic [TWC_W-1:0] twc_cnt_r;
  logic op_status_r;
  logic [ADDR_W-PAGE_W-1:0] page_r;
  logic [1:0] new_bp_r;
  logic [PAGE_W:0] prog_idx_r;
  logic prog_we_r;
  logic [PAGE_W-1:0] prog_low_r;
  logic [1:0] bp_r;
  logic wel_r;

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic sel;
  logic byte_done;
  logic cycle_end;
  logic start_ok;
  logic pb_we;
  logic [DATA_W-1:0] pb_rdata;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] status_byte;
  logic [DATA_W-1:0] out_byte;
  seep_cmd_e cmd;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sync1_r <= PINS_IDLE;
      sync2_r <= PINS_IDLE;
      sck_q_r <= 1'b0;
      cs_q_r <= 1'b1;
    end else if (clk_en_i) begin
      sync1_r <= pins_i;
      sync2_r <= sync1_r;
      sck_q_r <= sync2_r.sck;
      cs_q_r <= sync2_r.cs_n;
    end
  end

  assign sel = !sync2_r.cs_n;
  assign sck_rise = sync2_r.sck && !sck_q_r && sel && !paused_r;
  assign sck_fall = !sync2_r.sck && sck_q_r && sel && !paused_r;
  assign cs_fall = !sync2_r.cs_n && cs_q_r;
  assign cs_rise = sync2_r.cs_n && !cs_q_r;
  assign sh_nxt = {sh_r[DATA_W-2:0], sync2_r.si};
  assign byte_done = sck_rise && (bit_cnt_r == '1);
  assign cmd = decode_opc(sh_nxt);
  assign cycle_end = busy_r && (twc_cnt_r == TWC_LAST);

  always_comb begin
    status_byte = '0;
    status_byte[ST_BUSY] = busy_r;
    status_byte[ST_WEL] = wel_r;
    status_byte[ST_BP_LO] = bp_r[0];
    status_byte[ST_BP_HI] = bp_r[1];
  end

  assign out_byte = (state_r == ST_RDATA) ? mem_rdata : status_byte;
  assign pb_we = byte_done && (state_r == ST_WDATA);

  // pause follows hold only while the clock is low
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      paused_r <= 1'b0;
    end else if (clk_en_i) begin
      if (!sel) begin
        paused_r <= 1'b0;
      end else if (!sync2_r.sck) begin
        paused_r <= !sync2_r.hold_n;
      end
    end
  end

  // serial frame: shifting in, decoding and shifting out
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= '0;
      sh_r <= '0;
      ptr_r <= '0;
      is_wr_r <= 1'b0;
      got_byte_r <= 1'b0;
      latch_set_r <= 1'b0;
      stage_bp_r <= BP_RST;
      valid_r <= '0;
      osh_r <= '0;
      ocnt_r <= '0;
      drive_r <= 1'b0;
      so_r <= 1'b0;
    end else if (clk_en_i) begin
      if (!sel) begin
        state_r <= ST_IDLE;
        bit_cnt_r <= '0;
        ocnt_r <= '0;
        drive_r <= 1'b0;
      end else if (cs_fall) begin
        state_r <= ST_OPC;
        bit_cnt_r <= '0;
        ocnt_r <= '0;
        drive_r <= 1'b0;
      end else if (sck_rise) begin
        sh_r <= sh_nxt;
        bit_cnt_r <= bit_cnt_r + 1'b1;
        if (state_r == ST_LATCH) begin
          state_r <= ST_IGNORE;
        end else if (byte_done) begin
          unique case (state_r)
            ST_OPC: begin
              unique case (cmd)
                CMD_READ: begin
                  ptr_r[ADDR_W-1] <= sh_nxt[OPC_ADDR_BIT];
                  is_wr_r <= 1'b0;
                  state_r <= busy_r ? ST_IGNORE : ST_ADDR;
                end
                CMD_WRITE: begin
                  ptr_r[ADDR_W-1] <= sh_nxt[OPC_ADDR_BIT];
                  is_wr_r <= 1'b1;
                  valid_r <= busy_r ? valid_r : '0;
                  state_r <= busy_r ? ST_IGNORE : ST_ADDR;
                end
                CMD_LATCH_CLR: begin
                  latch_set_r <= 1'b0;
                  state_r <= ST_LATCH;
                end
                CMD_LATCH_SET: begin
                  latch_set_r <= 1'b1;
                  state_r <= ST_LATCH;
                end
                CMD_STAT_RD: begin
                  state_r <= ST_SREAD;
                end
                CMD_STAT_WR: begin
                  got_byte_r <= 1'b0;
                  state_r <= busy_r ? ST_IGNORE : ST_SWRITE;
                end
                CMD_BAD: begin
                  state_r <= ST_IGNORE;
                end
              endcase
            end
            ST_ADDR: begin
              ptr_r[DATA_W-1:0] <= sh_nxt;
              got_byte_r <= 1'b0;
              state_r <= is_wr_r ? ST_WDATA : ST_RDATA;
            end
            ST_WDATA: begin
              got_byte_r <= 1'b1;
              valid_r[ptr_r[PAGE_W-1:0]] <= 1'b1;
              ptr_r[PAGE_W-1:0] <= ptr_r[PAGE_W-1:0] + 1'b1;
            end
            ST_SWRITE: begin
              got_byte_r <= 1'b1;
              stage_bp_r <= {sh_nxt[ST_BP_HI], sh_nxt[ST_BP_LO]};
            end
            default: begin
            end
          endcase
        end
      end else if (sck_fall && (state_r == ST_RDATA || state_r == ST_SREAD)) begin
        drive_r <= 1'b1;
        ocnt_r <= ocnt_r + 1'b1;
        if (ocnt_r == '0) begin
          so_r <= out_byte[DATA_W-1];
          osh_r <= {out_byte[DATA_W-2:0], 1'b0};
          if (state_r == ST_RDATA) begin
            ptr_r <= ptr_r + 1'b1;
          end
        end else begin
          so_r <= osh_r[DATA_W-1];
          osh_r <= {osh_r[DATA_W-2:0], 1'b0};
        end
      end
    end
  end

  // a cycle starts only on a byte boundary with latch and pin allowing it, and for a page write the block as well
  always_comb begin
    start_ok = 1'b0;
    if (cs_rise && !busy_r && wel_r && sync2_r.wp_n && got_byte_r
        && bit_cnt_r == '0) begin
      if (state_r == ST_WDATA) begin
        start_ok = !is_protected(bp_r, {ptr_r[ADDR_W-1:PAGE_W], PAGE_W'(0)});
      end else if (state_r == ST_SWRITE) begin
        start_ok = 1'b1;
      end
    end
  end

  // self-timed write cycle and page programming
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      busy_r <= 1'b0;
      twc_cnt_r <= '0;
      op_status_r <= 1'b0;
      page_r <= '0;
      new_bp_r <= BP_RST;
      prog_idx_r <= '0;
      prog_we_r <= 1'b0;
      prog_low_r <= '0;
      bp_r <= BP_RST;
    end else if (clk_en_i) begin
      prog_we_r <= 1'b0;
      if (start_ok) begin
        busy_r <= 1'b1;
        twc_cnt_r <= '0;
        op_status_r <= (state_r == ST_SWRITE);
        page_r <= ptr_r[ADDR_W-1:PAGE_W];
        new_bp_r <= stage_bp_r;
        prog_idx_r <= '0;
      end else if (busy_r) begin
        twc_cnt_r <= twc_cnt_r + 1'b1;
        if (prog_idx_r != (PAGE_W+1)'(PAGE_BYTES)) begin
          prog_idx_r <= prog_idx_r + 1'b1;
          prog_low_r <= prog_idx_r[PAGE_W-1:0];
          prog_we_r <= !op_status_r && valid_r[prog_idx_r[PAGE_W-1:0]];
        end
        if (cycle_end) begin
          busy_r <= 1'b0;
          if (op_status_r) begin
            bp_r <= new_bp_r;
          end
        end
      end
    end
  end

  // write-enable latch
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wel_r <= WEL_RST;
    end else if (clk_en_i) begin
      if (!sync2_r.wp_n) begin
        wel_r <= 1'b0;
      end else if (cs_rise && state_r == ST_LATCH) begin
        wel_r <= latch_set_r;
      end else if (cycle_end) begin
        wel_r <= 1'b0;
      end
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      busy_o <= 1'b0;
      wel_o <= WEL_RST;
      status_o <= '0;
    end else if (clk_en_i) begin
      so_o <= so_r;
      so_oe_o <= sel && sync2_r.hold_n && drive_r;
      busy_o <= busy_r;
      wel_o <= wel_r;
      status_o <= status_byte;
    end
  end

  seep_mem #(
    .AW(PAGE_W)
  ) u_page_buf (
    .clk_i(ref_clk_i),
    .clk_en_i(clk_en_i),
    .we_i(pb_we),
    .waddr_i(ptr_r[PAGE_W-1:0]),
    .wdata_i(sh_nxt),
    .raddr_i(prog_idx_r[PAGE_W-1:0]),
    .rdata_o(pb_rdata)
  );

  seep_mem #(
    .AW(ADDR_W)
  ) u_array (
    .clk_i(ref_clk_i),
    .clk_en_i(clk_en_i),
    .we_i(prog_we_r),
    .waddr_i({page_r, prog_low_r}),
    .wdata_i(pb_rdata),
    .raddr_i(ptr_r),
    .rdata_o(mem_rdata)
  );

endmodule

// ===== hw/seep_pkg.sv
// shared constants, types and helpers for the serial memory port
package seep_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam int BIT_CNT_W = 3;
  localparam int TWC_W = 20;

  // self-timed write cycle, longest time, rounded down
  localparam int TWC_MS = 5;
  localparam int CLK_KHZ = 125000;
  localparam int TWC_CYCLES_DFLT = TWC_MS * CLK_KHZ;

  // opcodes; bit 3 carries the top address bit or is ignored
  localparam logic [7:0] OPC_IGN_MASK = 8'hF7;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_WRITE = 8'h02;
  localparam logic [7:0] OPC_LATCH_CLR = 8'h04;
  localparam logic [7:0] OPC_LATCH_SET = 8'h06;
  localparam logic [7:0] OPC_STAT_RD = 8'h05;
  localparam logic [7:0] OPC_STAT_WR = 8'h01;
  localparam int OPC_ADDR_BIT = 3;

  // status byte layout
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;

  // block protect codes and region starts
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QTR = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [ADDR_W-1:0] PROT_QTR_BASE = 9'h180;
  localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 9'h100;

  // values after reset
  localparam logic [1:0] BP_RST = 2'h0;
  localparam logic WEL_RST = 1'b0;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } seep_pins_s;

  localparam seep_pins_s PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};

  typedef enum logic [2:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_LATCH_CLR,
    CMD_LATCH_SET,
    CMD_STAT_RD,
    CMD_STAT_WR,
    CMD_BAD
  } seep_cmd_e;

  typedef enum {
    ST_IDLE,
    ST_OPC,
    ST_ADDR,
    ST_RDATA,
    ST_WDATA,
    ST_SREAD,
    ST_SWRITE,
    ST_LATCH,
    ST_IGNORE
  } seep_state_e;

  function automatic seep_cmd_e decode_opc(input logic [7:0] opc);
    logic [7:0] m;
    m = opc & OPC_IGN_MASK;
    if (m == OPC_READ) return CMD_READ;
    if (m == OPC_WRITE) return CMD_WRITE;
    if (m == OPC_LATCH_CLR) return CMD_LATCH_CLR;
    if (m == OPC_LATCH_SET) return CMD_LATCH_SET;
    if (m == OPC_STAT_RD) return CMD_STAT_RD;
    if (m == OPC_STAT_WR) return CMD_STAT_WR;
    return CMD_BAD;
  endfunction

  function automatic logic is_protected(input logic [1:0] bp, input logic [ADDR_W-1:0] addr);
    if (bp == BP_NONE) return 1'b0;
    if (bp == BP_QTR) return addr >= PROT_QTR_BASE;
    if (bp == BP_HALF) return addr >= PROT_HALF_BASE;
    return 1'b1;
  endfunction

endpackage

// ===== hw/seep_mem.sv
// simple dual-port byte memory with registered read data
module seep_mem #(
  parameter int AW = 9
) (
  input wire logic clk_i,
  input wire logic clk_en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [seep_pkg::DATA_W-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [seep_pkg::DATA_W-1:0] rdata_o
);
  import seep_pkg::*;

  logic [DATA_W-1:0] mem_r [2**AW];

  always_ff @(posedge clk_i) begin
    if (clk_en_i) begin
      if (we_i) begin
        mem_r[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule

// ===== testbench/seep_port_assertions.sv
// concurrent checks on the serial memory port flags and output enable
module seep_port_checker
  import seep_pkg::*;
#(
  parameter int unsigned TWC_CYCLES = 1000
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire seep_pkg::seep_pins_s pins_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic busy_o,
  input wire logic wel_o,
  input wire logic [seep_pkg::DATA_W-1:0] status_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [TWC_W-1:0] busy_cnt_r;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // busy cycles seen so far
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || !busy_o) begin
      busy_cnt_r <= '0;
    end else if (clk_en_i) begin
      busy_cnt_r <= busy_cnt_r + 1'b1;
    end
  end

  a_cycle_length: assert property ($fell(busy_o) |-> busy_cnt_r + 1 >= TWC_CYCLES
    && busy_cnt_r <= TWC_CYCLES + 1) else $error("write cycle length wrong");
  a_status_flags: assert property (status_o[1:0] == {wel_o, busy_o})
    else $error("status flags differ from ports");
  a_status_upper: assert property (status_o[7:4] == 4'h0)
    else $error("status upper bits not zero");
  a_deselect_float: assert property (pins_i.cs_n [*8] |-> !so_oe_o)
    else $error("output driven while deselected");
  a_hold_float: assert property (!pins_i.hold_n [*8] |-> !so_oe_o)
    else $error("output driven while paused");
  a_protect_clears_latch: assert property (!pins_i.wp_n [*6] |-> !wel_o)
    else $error("latch set while write protect low");
  a_busy_needs_latch: assert property ($rose(busy_o) |-> $past(wel_o) && pins_i.wp_n)
    else $error("write cycle started without latch");
  a_busy_on_deselect: assert property ($rose(busy_o) |-> pins_i.cs_n)
    else $error("write cycle started while selected");
  a_end_clears_latch: assert property ($fell(busy_o) |-> ##[0:1] !wel_o)
    else $error("latch not cleared at cycle end");
  a_latch_on_deselect: assert property ($rose(wel_o) |-> pins_i.cs_n)
    else $error("latch set while selected");
endmodule

// ===== testbench/seep_host.sv
// spi host model driving the port pins in mode 0
module seep_host
  import seep_pkg::*;
(
  input wire logic so_i,
  output seep_pkg::seep_pins_s pins_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    pins_o = PINS_IDLE;
  end

  task automatic start();
    #30 pins_o.cs_n = 1'b0;
    #60;
  endtask

  task automatic stop();
    #60 pins_o.cs_n = 1'b1;
    pins_o.si = ~pins_o.si;
    #250;
  endtask

  task automatic xbyte(input logic [7:0] tx, input int nb, input int pause,
                       output logic [7:0] rx);
    for (int i = 7; i > 7 - nb; i--) begin
      if (i == pause) begin
        pins_o.hold_n = 1'b0;
        #400 pins_o.hold_n = 1'b1;
        #60;
      end
      pins_o.si = tx[i];
      #62.5 pins_o.sck = 1'b1;
      rx[i] = so_i;
      #62.5 pins_o.sck = 1'b0;
    end
  endtask
endmodule

// ===== testbench/test_seep_port.sv
// self-checking bench for the serial memory port
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module test_seep_port;
  timeunit 1ns;
  timeprecision 100ps;
  import seep_pkg::*;
  localparam int unsigned TWC = 1000;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic clk_en_i = 1'b1;
  seep_pins_s pins;
  logic so, so_oe, busy, write_enable_latch_bit;
  logic so_line = 1'b0;
  logic [7:0] status, seen;
  logic [7:0] mem [512];
  logic [7:0] exp_q [$];
  logic [7:0] exp_v;
  int num_errors = 0;
  int num_checks = 0;
  event seen_ev;

  seep_port #(.TWC_CYCLES(TWC)) seep_port_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .clk_en_i(clk_en_i), .pins_i(pins), .so_o(so), .so_oe_o(so_oe), .busy_o(busy),
    .wel_o(write_enable_latch_bit), .status_o(status));
  seep_host seep_host_inst (.so_i(so_line), .pins_o(pins));

  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // released line shows no stale value
  always @(posedge ref_clk_i) so_line <= so_oe ? so : ~so_line;

  always @(seen_ev) begin
    exp_v = exp_q.pop_front();
    `CHK("serial byte", exp_v, seen)
  end

  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic frame(input logic [7:0] tx[$], input int nskip, input int pause, input bit cut);
    logic [7:0] r;
    seep_host_inst.start();
    foreach (tx[k]) begin
      seep_host_inst.xbyte(tx[k], (cut && k == tx.size() - 1) ? 4 : 8, (k == 2) ? pause : -1, r);
      if (k >= nskip) begin
        seen = r;
        ->seen_ev;
      end
    end
    seep_host_inst.stop();
  endtask

  task automatic stat(input logic [7:0] e);
    exp_q.push_back(e);
    frame({OPC_STAT_RD, 8'h00}, 1, -1, 0);
    `CHK("status port", e, status)
  endtask

  task automatic cmd(input logic [7:0] op);
    frame({op}, 99, -1, 0);
  endtask

  task automatic wait_idle();
    repeat (20) @(posedge ref_clk_i);
    for (int i = 0; i < 2 * TWC && busy !== 1'b0; i++) @(posedge ref_clk_i);
    `CHK("write cycle end", 1'b0, busy)
    if (busy !== 1'b0) begin
      end_sim();
    end
  endtask

  task automatic page_wr(input logic [8:0] a, input int n);
    logic [7:0] tx[$];
    logic [7:0] d;
    tx = {OPC_WRITE | {4'h0, a[8], 3'h0}, a[7:0]};
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom());
      tx.push_back(d);
      mem[{a[8:4], a[3:0] + 4'(k)}] = d;
    end
    cmd(OPC_LATCH_SET | 8'h08);
    frame(tx, 99, -1, 0);
    stat(8'h03);
    wait_idle();
  endtask

  task automatic rd(input logic [8:0] a, input int n, input int pause);
    logic [7:0] tx[$];
    tx = {OPC_READ | {4'h0, a[8], 3'h0}, a[7:0]};
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(mem[9'(a + k)]);
      tx.push_back(8'h00);
    end
    frame(tx, 2, pause, 0);
  endtask

  initial begin
    void'($urandom(73396));
    repeat (10) @(posedge ref_clk_i);
    #1 resetn_i = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    stat(8'h00);
    page_wr(9'h1FC, 6);
    page_wr(9'h000, 2);
    rd(9'h1FE, 4, -1);
    rd(9'h1F0, 2, 3);
    frame({OPC_LATCH_SET, OPC_WRITE, 8'h40, 8'h5A}, 99, -1, 0);
    stat(8'h00);
    cmd(OPC_LATCH_SET);
    frame({OPC_WRITE, 8'h40, 8'h5A, 8'hA5}, 99, -1, 1);
    stat(8'h02);
    cmd(OPC_LATCH_CLR | 8'h08);
    stat(8'h00);
    cmd(8'hF6);
    stat(8'h00);
    cmd(OPC_LATCH_SET);
    seep_host_inst.pins_o.wp_n = 1'b0;
    stat(8'h00);
    cmd(OPC_LATCH_SET);
    frame({OPC_WRITE, 8'h40, 8'h5A}, 99, -1, 0);
    stat(8'h00);
    seep_host_inst.pins_o.wp_n = 1'b1;
    cmd(OPC_LATCH_SET);
    frame({OPC_STAT_WR, 8'h04}, 99, -1, 0);
    stat(8'h03);
    wait_idle();
    stat(8'h04);
    cmd(OPC_LATCH_SET);
    frame({OPC_WRITE | 8'h08, 8'h80, 8'h11}, 99, -1, 0);
    stat(8'h06);
    frame({OPC_STAT_WR, 8'h00}, 99, -1, 0);
    wait_idle();
    stat(8'h00);
    rd(9'h1FF, 2, -1);
    end_sim();
  end
endmodule

bind seep_port seep_port_checker #(.TWC_CYCLES(TWC_CYCLES)) seep_port_checker_inst (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i), .pins_i(pins_i),
  .so_o(so_o), .so_oe_o(so_oe_o), .busy_o(busy_o), .wel_o(wel_o), .status_o(status_o));
